//--- ies_pkg.sv
`default_nettype none

package ies_pkg;

    // header nibbles
    localparam logic [3:0] HDR_MEM = 4'hA;
    localparam logic [3:0] HDR_SPC = 4'hB;

    // special space selector, bits 2:1 of the high address byte
    localparam int SPC_SEL_LSB = 1;
    localparam logic [1:0] SPC_SECURE = 2'h0;
    localparam logic [1:0] SPC_UID = 2'h1;
    localparam logic [1:0] SPC_LOCK = 2'h2;
    localparam logic [1:0] SPC_CFG = 2'h3;

    // configuration byte layout
    localparam int CFG_SEL_LSB = 5;
    localparam int CFG_SWP_BIT = 1;
    localparam logic [2:0] CFG_SEL_RST = 3'h0;
    localparam logic CFG_SWP_RST = 1'b0;
    localparam logic [2:0] CFG_UNUSED_HI = 3'h7;
    localparam logic CFG_UNUSED_LO = 1'b1;

    // lock
    localparam logic [7:0] LOCK_DATA = 8'hFF;
    localparam int LOCK_STAT_BIT = 1;

    // geometry
    localparam int MEM_AW = 13;
    localparam int PAGE_AW = 5;
    localparam int SEC_AW = 6;
    localparam int UID_AW = 4;
    localparam int BUF_DEPTH = 64;

    // timing
    localparam int CLK_KHZ = 40000;
    localparam int T_WR_MS = 5;
    localparam int WR_CYCLES_DEF = T_WR_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        TGT_MEM,
        TGT_SEC,
        TGT_UID,
        TGT_LOCK,
        TGT_CFG
    } ies_tgt_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HDR,
        ST_ADH,
        ST_ADL,
        ST_WDAT,
        ST_TX,
        ST_IGNORE
    } ies_state_e;

    typedef struct packed {
        logic [2:0] sel;
        logic soft_write_protect_flag;
    } ies_cfg_s;

endpackage

`default_nettype wire

//--- ies_slave.sv
// Functional notes
// - SDA falling while SCL high is START; receiver restarts on it.
// - SDA rising while SCL high is STOP; ends the current command.
// - all traffic ignored until a START has been seen.
// - header nibble 1010 selects the array, 1011 the special space.
// - next three header bits must match select bits; last bit is read/write.
// - select bits come up as zero.
// - matching header acknowledged by pulling SDA low on the ninth clock.
// - write address and data bytes acknowledged only if target not protected.
// - read shifts out bytes, releases ninth clock, continues while master acks.
// - byte write: header, two address bytes, data, STOP starts the write.
// - no header acknowledged while an internal write cycle runs.
// - array is 8192 bytes, 256 pages of 32; address names first byte.
// - page write offset wraps inside the page; STOP starts the write.
// - selective read loads the address counter then returns that data.
// - secure page write: second byte x00x, offset top two bits ignored.
// - lock: second byte x10x, data FFh; secure page then refuses writes.
// - configuration write: second byte x11x, data goes to the register.
// - configuration bits 7..5 are select bits, bit 1 protection flag.
// - protection flag set refuses array, secure page and lock writes.
// - while protected a config write can only clear the flag.
// - read header without address returns current address data.
// - sequential array read wraps only at end of memory.
// - unused config bits read as one.
// - 16-byte identifier read byte by byte, wrapping to its start.
// - lock status read: bit 1 set when the secure page is locked.
`timescale 1ns/10ps
`default_nettype none

module ies_slave #(
    parameter int unsigned WR_CYCLES = ies_pkg::WR_CYCLES_DEF,
    // identifier value is arbitrary
    parameter logic [127:0] UID_VALUE = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic busy_out
);

    localparam int CW = $clog2(WR_CYCLES + 1);
    localparam int MEM_BYTES = 1 << ies_pkg::MEM_AW;
    localparam int SEC_BYTES = 1 << ies_pkg::SEC_AW;

    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic scl_rise, scl_fall, start_det, stop_det;

    ies_pkg::ies_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] txd;
    logic [7:0] adh;
    logic spc_hdr;
    ies_pkg::ies_tgt_e tgt;
    ies_pkg::ies_tgt_e spc_tgt;
    logic m_ack;
    logic [ies_pkg::MEM_AW-1:0] addr;
    logic [ies_pkg::SEC_AW-1:0] sec_addr;
    logic [ies_pkg::UID_AW-1:0] uid_idx;
    logic [ies_pkg::SEC_AW-1:0] wr_off;
    logic [ies_pkg::MEM_AW-ies_pkg::PAGE_AW-1:0] wr_page;
    logic [ies_pkg::BUF_DEPTH-1:0] mask;
    logic pend_valid;
    logic lock_req;
    logic [7:0] cfg_new;

    ies_pkg::ies_cfg_s cfg;
    logic locked;
    logic [CW-1:0] busy_cnt;
    logic [ies_pkg::SEC_AW-1:0] commit_idx;
    logic commit_act;

    logic [7:0] mem [MEM_BYTES];
    logic [7:0] sec [SEC_BYTES];
    logic [7:0] wbuf [ies_pkg::BUF_DEPTH];

    logic buf_we;
    ies_pkg::ies_tgt_e adh_tgt;
    logic [7:0] rd_now;

    // target picked by the high address byte in the special space
    function automatic ies_pkg::ies_tgt_e spc_decode(input logic [7:0] b);
        unique case (b[ies_pkg::SPC_SEL_LSB +: 2])
            ies_pkg::SPC_SECURE: spc_decode = ies_pkg::TGT_SEC;
            ies_pkg::SPC_UID: spc_decode = ies_pkg::TGT_UID;
            ies_pkg::SPC_LOCK: spc_decode = ies_pkg::TGT_LOCK;
            ies_pkg::SPC_CFG: spc_decode = ies_pkg::TGT_CFG;
        endcase
    endfunction

    // may this target take a written data byte now
    function automatic logic wr_ok(input ies_pkg::ies_tgt_e t, input logic soft_write_protect_flag, input logic lck);
        unique case (t)
            ies_pkg::TGT_MEM: wr_ok = !soft_write_protect_flag;
            ies_pkg::TGT_SEC: wr_ok = !soft_write_protect_flag && !lck;
            ies_pkg::TGT_LOCK: wr_ok = !soft_write_protect_flag && !lck;
            ies_pkg::TGT_CFG: wr_ok = 1'b1;
            ies_pkg::TGT_UID: wr_ok = 1'b0;
        endcase
    endfunction

    // pin synchronisers; only the second stage and its delayed copy are looked at
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    // both lines move through equal stages, so SCL high is judged on the same sample
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;

    assign adh_tgt = spc_hdr ? spc_decode(sh) : ies_pkg::TGT_MEM;

    // read data for the current target
    always_comb begin
        rd_now = 8'h00;
        unique case (tgt)
            ies_pkg::TGT_MEM: rd_now = mem[addr];
            ies_pkg::TGT_SEC: rd_now = sec[sec_addr];
            ies_pkg::TGT_UID: rd_now = UID_VALUE[{~uid_idx, 3'h0} +: 8];
            ies_pkg::TGT_LOCK: rd_now = 8'(locked) << ies_pkg::LOCK_STAT_BIT;
            ies_pkg::TGT_CFG: rd_now = {cfg.sel, ies_pkg::CFG_UNUSED_HI, cfg.soft_write_protect_flag, ies_pkg::CFG_UNUSED_LO};
        endcase
    end

    assign buf_we = scl_fall && (bit_cnt == 4'h8) && (state == ies_pkg::ST_WDAT)
                    && (tgt == ies_pkg::TGT_MEM || tgt == ies_pkg::TGT_SEC)
                    && wr_ok(tgt, cfg.soft_write_protect_flag, locked);

    // page buffer; later bytes at the same offset overwrite earlier ones
    always_ff @(posedge mclk_in) begin
        if (buf_we) begin
            wbuf[wr_off] <= sh;
        end
    end

    // bus protocol
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ies_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            sh <= 8'h00;
            txd <= 8'h00;
            adh <= 8'h00;
            spc_hdr <= 1'b0;
            tgt <= ies_pkg::TGT_MEM;
            spc_tgt <= ies_pkg::TGT_SEC;
            m_ack <= 1'b0;
            addr <= '0;
            sec_addr <= '0;
            uid_idx <= '0;
            wr_off <= '0;
            wr_page <= '0;
            mask <= '0;
            pend_valid <= 1'b0;
            lock_req <= 1'b0;
            cfg_new <= 8'h00;
            sda_oe_out <= 1'b0;
        end else if (start_det) begin
            state <= ies_pkg::ST_HDR;
            bit_cnt <= 4'h0;
            pend_valid <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (stop_det) begin
            state <= ies_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            pend_valid <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (state != ies_pkg::ST_IDLE && state != ies_pkg::ST_IGNORE) begin
            if (scl_rise) begin
                if (bit_cnt < 4'h8) begin
                    sh <= {sh[6:0], sda_s2};
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (bit_cnt == 4'h9) begin
                    m_ack <= !sda_s2;
                end
            end else if (scl_fall) begin
                if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h9;
                    unique case (state)
                        ies_pkg::ST_HDR: begin
                            if ((sh[7:4] == ies_pkg::HDR_MEM || sh[7:4] == ies_pkg::HDR_SPC)
                                && sh[3:1] == cfg.sel && !busy_out) begin
                                sda_oe_out <= 1'b1;
                                spc_hdr <= sh[4];
                                if (sh[0]) begin
                                    state <= ies_pkg::ST_TX;
                                    tgt <= sh[4] ? spc_tgt : ies_pkg::TGT_MEM;
                                end else begin
                                    state <= ies_pkg::ST_ADH;
                                    mask <= '0;
                                    lock_req <= 1'b0;
                                end
                            end else begin
                                state <= ies_pkg::ST_IGNORE;
                            end
                        end
                        ies_pkg::ST_ADH: begin
                            adh <= sh;
                            tgt <= adh_tgt;
                            if (spc_hdr) begin
                                spc_tgt <= adh_tgt;
                            end
                            sda_oe_out <= adh_tgt == ies_pkg::TGT_UID || wr_ok(adh_tgt, cfg.soft_write_protect_flag, locked);
                            state <= ies_pkg::ST_ADL;
                        end
                        ies_pkg::ST_ADL: begin
                            addr <= {adh[ies_pkg::MEM_AW-9:0], sh};
                            sec_addr <= sh[ies_pkg::SEC_AW-1:0];
                            uid_idx <= sh[ies_pkg::UID_AW-1:0];
                            wr_page <= {adh[ies_pkg::MEM_AW-9:0], sh[7:ies_pkg::PAGE_AW]};
                            wr_off <= (tgt == ies_pkg::TGT_MEM) ? {1'b0, sh[ies_pkg::PAGE_AW-1:0]}
                                                                : sh[ies_pkg::SEC_AW-1:0];
                            sda_oe_out <= tgt == ies_pkg::TGT_UID || wr_ok(tgt, cfg.soft_write_protect_flag, locked);
                            state <= ies_pkg::ST_WDAT;
                        end
                        ies_pkg::ST_WDAT: begin
                            if (wr_ok(tgt, cfg.soft_write_protect_flag, locked)) begin
                                sda_oe_out <= 1'b1;
                                pend_valid <= 1'b1;
                                unique case (tgt)
                                    ies_pkg::TGT_MEM: begin
                                        mask[wr_off] <= 1'b1;
                                        wr_off <= {1'b0, wr_off[ies_pkg::PAGE_AW-1:0] + 5'h1};
                                    end
                                    ies_pkg::TGT_SEC: begin
                                        mask[wr_off] <= 1'b1;
                                        wr_off <= wr_off + 6'h1;
                                    end
                                    ies_pkg::TGT_LOCK: lock_req <= sh == ies_pkg::LOCK_DATA;
                                    ies_pkg::TGT_CFG: cfg_new <= sh;
                                    ies_pkg::TGT_UID: lock_req <= lock_req;
                                endcase
                            end
                        end
                        ies_pkg::ST_TX: begin
                            sda_oe_out <= 1'b0;
                        end
                        default: begin
                            state <= ies_pkg::ST_IGNORE;
                        end
                    endcase
                end else if (bit_cnt == 4'h9) begin
                    bit_cnt <= 4'h0;
                    sda_oe_out <= 1'b0;
                    if (state == ies_pkg::ST_TX && m_ack) begin
                        // own header ack reads back low, so it counts as a master ack too
                        txd <= rd_now;
                        sda_oe_out <= !rd_now[7];
                        m_ack <= 1'b0;
                        unique case (tgt)
                            ies_pkg::TGT_MEM: addr <= addr + 13'h1;
                            ies_pkg::TGT_SEC: sec_addr <= sec_addr + 6'h1;
                            ies_pkg::TGT_UID: uid_idx <= uid_idx + 4'h1;
                            ies_pkg::TGT_LOCK: addr <= addr;
                            ies_pkg::TGT_CFG: addr <= addr;
                        endcase
                    end else if (state == ies_pkg::ST_TX) begin
                        state <= ies_pkg::ST_IGNORE;
                    end else if (!sda_oe_out) begin
                        state <= ies_pkg::ST_IGNORE;
                    end
                end else if (state == ies_pkg::ST_TX && bit_cnt != 4'h0) begin
                    sda_oe_out <= !txd[6];
                    txd <= {txd[6:0], 1'b0};
                end
            end
        end
    end

    // internal write cycle, started only by STOP after accepted data
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
            busy_cnt <= '0;
            commit_idx <= '0;
            commit_act <= 1'b0;
            cfg.sel <= ies_pkg::CFG_SEL_RST;
            cfg.soft_write_protect_flag <= ies_pkg::CFG_SWP_RST;
            locked <= 1'b0;
        end else if (stop_det && pend_valid && !busy_out) begin
            busy_out <= 1'b1;
            busy_cnt <= '0;
            commit_idx <= '0;
            commit_act <= tgt == ies_pkg::TGT_MEM || tgt == ies_pkg::TGT_SEC;
            if (tgt == ies_pkg::TGT_LOCK && lock_req) begin
                locked <= 1'b1;
            end
            if (tgt == ies_pkg::TGT_CFG) begin
                cfg.soft_write_protect_flag <= cfg_new[ies_pkg::CFG_SWP_BIT];
                if (!cfg.soft_write_protect_flag) begin
                    cfg.sel <= cfg_new[ies_pkg::CFG_SEL_LSB +: 3];
                end
            end
        end else if (busy_out) begin
            if (busy_cnt == CW'(WR_CYCLES - 1)) begin
                busy_out <= 1'b0;
            end
            busy_cnt <= busy_cnt + CW'(1);
            if (commit_idx == 6'(ies_pkg::BUF_DEPTH - 1)) begin
                commit_act <= 1'b0;
            end
            commit_idx <= commit_idx + 6'h1;
        end
    end

    // array and secure page programming, one buffered byte per cycle of the write time
    always_ff @(posedge mclk_in) begin
        if (busy_out && commit_act && mask[commit_idx]) begin
            if (tgt == ies_pkg::TGT_MEM) begin
                mem[{wr_page, commit_idx[ies_pkg::PAGE_AW-1:0]}] <= wbuf[commit_idx];
            end else begin
                sec[commit_idx] <= wbuf[commit_idx];
            end
        end
    end

    // open drain: the pin only ever pulls low
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- ies_chk.sv
`timescale 1ns/10ps
`default_nettype none

module ies_chk #(
    parameter int unsigned WR_CYCLES = 200
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic busy_out
);
    logic [31:0] busy_cnt;
    logic sda_q;
    logic start_seen;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    // raw pins, ahead of the device synchronisers, so never later than the device
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_q <= 1'b1;
            start_seen <= 1'b0;
            busy_cnt <= 32'h0;
        end else begin
            sda_q <= sda_in;
            start_seen <= start_seen | (scl_in & sda_q & ~sda_in);
            busy_cnt <= busy_out ? busy_cnt + 32'h1 : 32'h0;
        end
    end

    property p_drive_low; sda_out == 1'b0; endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda drive value not low");
    property p_quiet_reset; !start_seen |-> !sda_oe_out; endproperty
    a_quiet_reset: assert property (p_quiet_reset) else $error("sda pulled before any start");
    property p_busy_len; $fell(busy_out) |-> busy_cnt == WR_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length differs from write time");
    property p_busy_at_stop; $rose(busy_out) |-> scl_in && sda_in && !$past(sda_in, 5); endproperty
    a_busy_at_stop: assert property (p_busy_at_stop) else $error("busy rose without a stop");
    property p_no_ack_busy; busy_out |-> !sda_oe_out; endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("sda pulled while busy");
    property p_change_low; $changed(sda_oe_out) |-> !$past(scl_in); endproperty
    a_change_low: assert property (p_change_low) else $error("sda changed while scl high");
    property p_hold_high; $rose(scl_in) && sda_oe_out |-> sda_oe_out [*4]; endproperty
    a_hold_high: assert property (p_hold_high) else $error("low bit not held over scl high");
    property p_ack_spans; $rose(sda_oe_out) |-> ##[1:8] (scl_in && sda_oe_out); endproperty
    a_ack_spans: assert property (p_ack_spans) else $error("pulled bit missed the next scl high");

    c_busy: cover property ($rose(busy_out));
    c_ack: cover property ($rose(scl_in) && sda_oe_out);
    c_done: cover property ($fell(busy_out));
endmodule

bind ies_slave ies_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .busy_out(busy_out)
);

`default_nettype wire

//--- ies_master.sv
`timescale 1ns/10ps
`default_nettype none

module ies_master (
    input wire logic mclk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    event got;
    logic [7:0] got_val;

    // both lines released to the pull-up; scl stands still between frames
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // read back at the end of high, well past the device output latency
    task automatic put(input logic d, output logic q);
        tick(2);
        sda_out <= d;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        q = sda_in;
        scl_out <= 1'b0;
    endtask

    // long low phase lets a pending ack release settle first
    task automatic start();
        tick(2);
        sda_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b0;
        tick(4);
        scl_out <= 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_out <= 1'b0;
        tick(2);
        scl_out <= 1'b1;
        tick(4);
        sda_out <= 1'b1;
        tick(4);
    endtask

    task automatic send(input logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            put(b[i], q);
        end
        put(1'b1, q);
        got_val = {7'h00, ~q};
        ->got;
    endtask

    task automatic recv(input logic ack);
        logic q;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            put(1'b1, q);
            v[i] = q;
        end
        put(~ack, q);
        got_val = v;
        ->got;
    endtask
endmodule

`default_nettype wire

//--- ies_tb.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int unsigned WR = 200;
    // identifier value is arbitrary
    localparam logic [127:0] UID = 128'h3C5A96E1D2B4780F1E2D3C4B5A697887;
    logic mclk;
    logic rst_n;
    logic scl;
    logic sda_drv;
    logic oe;
    logic sda_d;
    logic busy;
    wire logic sda_line = sda_drv & ~oe;
    logic [8:0] exp_q[$];
    logic [7:0] mem [int];
    logic [7:0] bad [4] = '{8'hC0, 8'hA2, 8'hBE, 8'h50};
    logic [7:0] d;
    logic [8:0] e;
    int miscompares;
    int compares;

    ies_slave #(.WR_CYCLES(WR), .UID_VALUE(UID)) dut (.mclk_in(mclk), .rst_n_in(rst_n), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_d), .sda_oe_out(oe), .busy_out(busy));
    ies_master m (.mclk_in(mclk), .sda_in(sda_line), .scl_out(scl), .sda_out(sda_drv));

    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    task automatic check_ack(input logic x, input logic s);
        compares++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected ack: expected %0b, seen %0b", x, s);
        end
    endtask

    task automatic check_byte(input logic [7:0] x, input logic [7:0] s);
        compares++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected byte: expected %02h, seen %02h", x, s);
        end
    endtask

    task automatic wb(input logic [7:0] b, input logic a);
        exp_q.push_back({1'b0, 7'h00, a});
        m.send(b);
    endtask

    task automatic rb(input logic [7:0] x, input logic ack);
        exp_q.push_back({1'b1, x});
        m.recv(ack);
    endtask

    task automatic cmd(input logic [7:0] h, input logic [7:0] ah, input logic [7:0] al);
        m.start();
        wb(h, 1'b1);
        wb(ah, 1'b1);
        wb(al, 1'b1);
    endtask

    task automatic cfg_read(input logic [7:0] h, input logic [7:0] x);
        cmd(h, 8'h06, 8'h00);
        m.start();
        wb(h | 8'h01, 1'b1);
        rb(x, 1'b0);
        m.stop();
    endtask

    // no polling after a configuration write: wait out the write time
    task automatic cfg_write(input logic [7:0] h, input logic [7:0] v);
        cmd(h, 8'h06, 8'h5A);
        wb(v, 1'b1);
        m.stop();
        m.tick(WR + 16);
    endtask

    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        forever begin
            @(m.got);
            e = exp_q.pop_front();
            if (e[8]) begin
                check_byte(e[7:0], m.got_val);
            end else begin
                check_ack(e[0], m.got_val[0]);
            end
        end
    end

    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        $display("unexpected run length: expected done, seen running");
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        miscompares = 0;
        compares = 0;
        void'($urandom(93));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        m.tick(4);
        foreach (bad[i]) begin
            m.start();
            wb(bad[i], 1'b0);
            m.stop();
        end
        d = 8'($urandom());
        mem[0] = d;
        cmd(8'hA0, 8'h00, 8'h00);
        wb(d, 1'b1);
        m.stop();
        m.start();
        wb(8'hA0, 1'b0);
        m.stop();
        m.tick(WR + 16);
        cmd(8'hA0, 8'h1F, 8'hFE);
        for (int i = 0; i < 34; i++) begin
            d = 8'($urandom());
            mem[8160 + (30 + i) % 32] = d;
            wb(d, 1'b1);
        end
        m.stop();
        m.tick(WR + 16);
        cmd(8'hA0, 8'h1F, 8'hFD);
        m.start();
        wb(8'hA1, 1'b1);
        rb(mem[8189], 1'b1);
        rb(mem[8190], 1'b0);
        m.stop();
        m.start();
        wb(8'hA1, 1'b1);
        rb(mem[8191], 1'b1);
        rb(mem[0], 1'b0);
        m.stop();
        d = 8'($urandom());
        cmd(8'hB0, 8'hF8, 8'hC5);
        wb(d, 1'b1);
        m.stop();
        m.tick(WR + 16);
        cmd(8'hB0, 8'h00, 8'h05);
        m.start();
        wb(8'hB1, 1'b1);
        rb(d, 1'b0);
        m.stop();
        cmd(8'hB0, 8'h02, 8'h00);
        m.start();
        wb(8'hB1, 1'b1);
        for (int i = 0; i < 17; i++) begin
            rb(UID[127 - 8 * (i % 16) -: 8], i < 16);
        end
        m.stop();
        cmd(8'hB0, 8'h04, 8'h3C);
        wb(8'hFF, 1'b1);
        m.stop();
        m.tick(WR + 16);
        m.start();
        wb(8'hB0, 1'b1);
        wb(8'hF8, 1'b0);
        m.stop();
        m.start();
        wb(8'hB0, 1'b1);
        wb(8'h04, 1'b0);
        m.start();
        wb(8'hB1, 1'b1);
        rb(8'h02, 1'b0);
        m.stop();
        cfg_read(8'hB0, 8'h1D);
        cfg_write(8'hB0, 8'h02);
        cfg_read(8'hB0, 8'h1F);
        m.start();
        wb(8'hA0, 1'b1);
        wb(8'h00, 1'b0);
        m.stop();
        cfg_write(8'hB0, 8'hE0);
        cfg_read(8'hB0, 8'h1D);
        cfg_write(8'hB0, 8'hA0);
        m.start();
        wb(8'hB0, 1'b0);
        m.stop();
        cfg_read(8'hBA, 8'hBD);
        m.tick(20);
        wrap_up();
    end
endmodule

`default_nettype wire
